// ===== design/bcx_pkg.sv
// Package with register map, field layout and oscillator control reset value of the bias/crystal bank
package bcx_pkg;
  localparam logic [7:0] BCX_OFF_BIAS_STS = 8'h00;
  localparam logic [7:0] BCX_OFF_XO_CTRL = 8'h04;
  localparam logic [7:0] BCX_OFF_IRQ_STS = 8'h08;
  localparam logic [7:0] BCX_OFF_IRQ_EN = 8'h0C;
  localparam logic [7:0] BCX_OFF_IRQ_CLR = 8'h10;
  localparam int BCX_DONE_BIT = 0;
  localparam int BCX_FAIL_BIT = 1;
  localparam int BCX_CODE_LSB = 2;
  localparam int BCX_EFF_LSB = 5;
  localparam int BCX_CMP_BIT = 8;
  localparam int BCX_XIN_LSB = 0;
  localparam int BCX_XO_RSV_LSB = 6;
  localparam int BCX_XOUT_LSB = 8;
  localparam int BCX_GAIN_LSB = 14;
  localparam int BCX_LDO_BIT = 16;
  localparam int BCX_SPARE_LSB = 17;
  localparam logic [18:0] BCX_XO_WMASK = 19'h7FFFF;
  localparam logic [18:0] BCX_XO_RESET = 19'h15F1F;
  localparam logic [1:0] BCX_RESP_OKAY = 2'h0;
  localparam logic [1:0] BCX_RESP_SLVERR = 2'h2;
  localparam int BCX_NUM_EVT = 2;
  typedef enum logic [1:0] {BCX_W_IDLE, BCX_W_RESP} bcx_wstate_type;
  typedef enum logic [1:0] {BCX_R_IDLE, BCX_R_DATA} bcx_rstate_type;
endpackage

// ===== design/bcx_top.sv
// Bias calibration status and crystal oscillator control bank on AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module bcx_top
  import bcx_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cal_done,
  input wire logic cal_fail,
  input wire logic [2:0] cal_code,
  input wire logic [2:0] cal_code_eff,
  input wire logic cal_cmp,
  output logic oscillator_regulator_enable,
  output logic [1:0] xo_gain_boost,
  output logic [5:0] xo_cap_out,
  output logic [5:0] xo_cap_in,
  output logic irq
);

  typedef struct packed {
    bcx_wstate_type wst;
    bcx_rstate_type rst;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [18:0] xo;
    logic done_prev;
    logic [BCX_NUM_EVT-1:0] ists;
    logic [BCX_NUM_EVT-1:0] ien;
    logic irq;
  } bcx_state_type;

  bcx_state_type s_q, s_d;
  logic [15:0] bias_word;
  logic [31:0] wmask;
  logic [BCX_NUM_EVT-1:0] evt;
  logic [BCX_NUM_EVT-1:0] clr;

  always_comb begin
    // Status reads track live inputs; unused upper bits stay zero
    bias_word = '0;
    bias_word[BCX_DONE_BIT] = cal_done;
    bias_word[BCX_FAIL_BIT] = cal_fail;
    bias_word[BCX_CODE_LSB +: 3] = cal_code;
    bias_word[BCX_EFF_LSB +: 3] = cal_code_eff;
    bias_word[BCX_CMP_BIT] = cal_cmp;
    wmask = {{8{s_q.wstrb[3]}}, {8{s_q.wstrb[2]}}, {8{s_q.wstrb[1]}}, {8{s_q.wstrb[0]}}};
    // Events: calibration completes, and completes with failure
    evt[0] = cal_done & ~s_q.done_prev;
    evt[1] = cal_done & ~s_q.done_prev & cal_fail;
    clr = '0;

    s_d = s_q;
    s_d.done_prev = cal_done;

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
      s_d.awready = 1'b0;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
      s_d.wready = 1'b0;
    end
    case (s_q.wst)
      BCX_W_IDLE: begin
        if (s_q.aw_got && s_q.w_got) begin
          s_d.bresp = BCX_RESP_OKAY;
          case (s_q.awaddr)
            BCX_OFF_XO_CTRL: begin
              // Reserved read-only bits 31:19 are outside the stored field
              s_d.xo = (s_q.xo & ~(wmask[18:0] & BCX_XO_WMASK))
                     | (s_q.wdata[18:0] & wmask[18:0] & BCX_XO_WMASK);
            end
            BCX_OFF_IRQ_EN: begin
              if (s_q.wstrb[0]) begin
                s_d.ien = s_q.wdata[BCX_NUM_EVT-1:0];
              end
            end
            BCX_OFF_IRQ_CLR: begin
              if (s_q.wstrb[0]) begin
                clr = s_q.wdata[BCX_NUM_EVT-1:0];
              end
            end
            BCX_OFF_BIAS_STS, BCX_OFF_IRQ_STS: begin
              s_d.bresp = BCX_RESP_OKAY;
            end
            default: begin
              s_d.bresp = BCX_RESP_SLVERR;
            end
          endcase
          s_d.bvalid = 1'b1;
          s_d.aw_got = 1'b0;
          s_d.w_got = 1'b0;
          s_d.wst = BCX_W_RESP;
        end
      end
      BCX_W_RESP: begin
        if (s_axi_bready) begin
          s_d.bvalid = 1'b0;
          s_d.awready = 1'b1;
          s_d.wready = 1'b1;
          s_d.wst = BCX_W_IDLE;
        end
      end
      default: begin
        s_d.wst = BCX_W_IDLE;
      end
    endcase

    // Set wins over a clear arriving in the same cycle
    s_d.ists = (s_q.ists & ~clr) | evt;
    s_d.irq = |(s_d.ists & s_d.ien);

    case (s_q.rst)
      BCX_R_IDLE: begin
        if (s_axi_arvalid) begin
          s_d.arready = 1'b0;
          s_d.rvalid = 1'b1;
          s_d.rresp = BCX_RESP_OKAY;
          s_d.rdata = '0;
          // Narrow registers sit in the low bits; the rest of the word reads zero
          case (s_axi_araddr)
            BCX_OFF_BIAS_STS: begin
              s_d.rdata[15:0] = bias_word;
            end
            BCX_OFF_XO_CTRL: begin
              s_d.rdata[18:0] = s_q.xo;
            end
            BCX_OFF_IRQ_STS: begin
              s_d.rdata[BCX_NUM_EVT-1:0] = s_q.ists;
            end
            BCX_OFF_IRQ_EN: begin
              s_d.rdata[BCX_NUM_EVT-1:0] = s_q.ien;
            end
            BCX_OFF_IRQ_CLR: begin
              // Clear register is write-only
              s_d.rdata = '0;
            end
            default: begin
              s_d.rresp = BCX_RESP_SLVERR;
            end
          endcase
          s_d.rst = BCX_R_DATA;
        end
      end
      BCX_R_DATA: begin
        if (s_axi_rready) begin
          s_d.rvalid = 1'b0;
          s_d.arready = 1'b1;
          s_d.rst = BCX_R_IDLE;
        end
      end
      default: begin
        s_d.rst = BCX_R_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.wst <= BCX_W_IDLE;
      s_q.rst <= BCX_R_IDLE;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.xo <= BCX_XO_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign oscillator_regulator_enable = s_q.xo[BCX_LDO_BIT];
  assign xo_gain_boost = s_q.xo[BCX_GAIN_LSB +: 2];
  assign xo_cap_out = s_q.xo[BCX_XOUT_LSB +: 6];
  assign xo_cap_in = s_q.xo[BCX_XIN_LSB +: 6];
  assign irq = s_q.irq;

endmodule
`default_nettype wire

// ===== tb/bcx_monitor.sv
// Checker for the bias/crystal register bank
`timescale 1ns/1ps
`default_nettype none
module bcx_monitor
  import bcx_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic cal_done,
  input wire logic cal_fail,
  input wire logic [2:0] cal_code,
  input wire logic [2:0] cal_code_eff,
  input wire logic cal_cmp,
  input wire logic oscillator_regulator_enable,
  input wire logic [1:0] xo_gain_boost,
  input wire logic [5:0] xo_cap_out,
  input wire logic [5:0] xo_cap_in,
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Status is live: it must match the inputs seen at the take edge
  sequence bias_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == BCX_OFF_BIAS_STS;
  endsequence
  done_flag_a: assert property (bias_rd |=> s_axi_rdata[0] == $past(cal_done))
    else $error("done flag wrong");
  fail_flag_a: assert property (bias_rd |=> s_axi_rdata[1] == $past(cal_fail))
    else $error("fail flag wrong");
  chosen_code_a: assert property (bias_rd |=> s_axi_rdata[4:2] == $past(cal_code))
    else $error("chosen code wrong");
  eff_code_a: assert property (bias_rd |=> s_axi_rdata[7:5] == $past(cal_code_eff))
    else $error("effective code wrong");
  raw_cmp_a: assert property (bias_rd |=> s_axi_rdata[8] == $past(cal_cmp))
    else $error("comparator bit wrong");
  status_rsv_a: assert property (bias_rd |=> s_axi_rdata[31:9] == '0)
    else $error("reserved status bits set");
  xo_reset_a: assert property ($rose(resetn) |-> {oscillator_regulator_enable, xo_gain_boost,
    xo_cap_out, xo_cap_in} == 15'h57DF)
    else $error("oscillator reset value wrong");
  ldo_write_a: assert property ($changed(oscillator_regulator_enable) |-> $rose(s_axi_bvalid))
    else $error("regulator enable moved without a write");
  irq_reset_a: assert property ($rose(resetn) |-> !irq)
    else $error("interrupt high out of reset");
endmodule
bind bcx_top bcx_monitor u_bcx_monitor (.*);
`default_nettype wire

// ===== tb/bcx_top_tb.sv
// Self-checking bench for the bias/crystal register bank
`timescale 1ns/1ps
`default_nettype none
module bcx_top_tb;
  import bcx_pkg::*;
  localparam logic [1:0] OK = BCX_RESP_OKAY;
  // Response readies stay high: the bench never refuses an answer
  logic mclk = '0, resetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '1;
  logic s_axi_arvalid = '0, s_axi_rready = '1, cal_done = '0, cal_fail = '0, cal_cmp = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] cal_code = '0, cal_code_eff = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, xo_gain_boost;
  logic oscillator_regulator_enable;
  logic [5:0] xo_cap_out, xo_cap_in;
  logic [33:0] q[$];
  int n_errors = 0, tests_run = 0, cyc = 0;
  bcx_top u_bcx_top (.*);
  initial forever #5 mclk = ~mclk;
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("Error result expected %h seen %h", e, s);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, q.pop_front());
    if (cyc == 5000) begin
      n_errors++;
      complete_run;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] w, input logic [1:0] r);
    q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= w;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge mclk); while (!s_axi_rvalid);
  endtask
  initial begin
    void'($urandom(86206));
    repeat (3) @(posedge mclk);
    resetn <= 1'h1;
    rd(BCX_OFF_XO_CTRL, {OK, 32'h0001_5F1F});
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      {cal_cmp, cal_code_eff, cal_code, cal_fail, cal_done} <= d[8:0];
      rd(BCX_OFF_BIAS_STS, {OK, 23'h0, d[8:0]});
    end
    $display("bias status done");
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      d[16:14] = {i[1], i[1:0]};
      // Capacitance kept to the legal range, both ends of it
      d[13:8] = i[0] ? 6'h00 : 6'h2F;
      d[5:0] = i[0] ? 6'h2F : 6'h00;
      wr(BCX_OFF_XO_CTRL, d, OK);
      chk({oscillator_regulator_enable, xo_gain_boost, xo_cap_out, xo_cap_in}, {d[16:8], d[5:0]});
      rd(BCX_OFF_XO_CTRL, {OK, 13'h0, d[18:0]});
    end
    wr(BCX_OFF_BIAS_STS, 32'hFFFF_FFFF, OK);
    wr(8'h14, 32'h0, BCX_RESP_SLVERR);
    rd(8'h14, {BCX_RESP_SLVERR, 32'h0});
    $display("access kinds done");
    cal_done <= 1'h0;
    wr(BCX_OFF_IRQ_CLR, 32'h3, OK);
    wr(BCX_OFF_IRQ_EN, 32'h1, OK);
    cal_fail <= 1'h1;
    cal_done <= 1'h1;
    repeat (3) @(posedge mclk);
    rd(BCX_OFF_IRQ_STS, {OK, 32'h3});
    chk(irq, 1'h1);
    wr(BCX_OFF_IRQ_EN, 32'h0, OK);
    @(posedge mclk);
    chk(irq, 1'h0);
    wr(BCX_OFF_IRQ_CLR, 32'h3, OK);
    rd(BCX_OFF_IRQ_STS, {OK, 32'h0});
    $display("interrupt done");
    complete_run;
  end
endmodule
`default_nettype wire
